// File: logic/selftest_pkg.sv
/*
 * Shared constants and carrier types for the startup self-test and fault report logic.
 * Assumes one 100 MHz clock and that all comparator inputs are synchronous to it.
 */
package selftest_pkg;

	// ****************************************************************
	// Rail indices and counts
	// ****************************************************************
	localparam int RAIL_COUNT = 5;
	localparam int RAIL_PREREG = 0;
	localparam int RAIL_UC = 1;
	localparam int RAIL_GEN5V = 2;
	localparam int RAIL_SENS1 = 3;
	localparam int RAIL_SENS2 = 4;
	localparam logic [4:0] RAILS_ALL = 5'h1F;
	localparam logic [4:0] RAILS_NONE = 5'h00;

	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int CLK_MHZ = 100;
	localparam int STEP_TIME_US = 10;
	localparam int STEP_CYCLES = STEP_TIME_US * CLK_MHZ;
	localparam int CNT_W = 12;
	localparam logic [11:0] CNT_ZERO = 12'h000;
	localparam logic [11:0] STEP_LAST = 12'(STEP_CYCLES - 1);

	// ****************************************************************
	// Verify result register 0 layout
	// ****************************************************************
	localparam int VR0_OVERTEMP_BIT = 0;
	localparam logic [7:0] VR0_RESET = 8'h00;

	// ****************************************************************
	// Sequencer states
	// ****************************************************************
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_UV_TEST = 3'b001,
		ST_OV_TEST = 3'b010,
		ST_OT_TEST = 3'b011,
		ST_SETTLE = 3'b100,
		ST_DONE = 3'b101
	} seq_state_t;

	// ****************************************************************
	// Carrier types
	// ****************************************************************
	typedef struct packed {
		logic [4:0] uvVerify;
		logic [4:0] ovVerify;
		logic overtempVerify;
		logic uvFail;
		logic ovFail;
		logic overtempFail;
		logic testDone;
		logic enableOutputMatchOk;
	} status_t;

	typedef struct packed {
		logic [4:0] uvDiag;
		logic [4:0] ovDiag;
		logic overtempDiag;
	} detect_t;

endpackage

// File: logic/verify_latch.sv
/*
 * One sticky verify bit, set when its diagnostic bit changes while its test is armed.
 * Assumes the diagnostic bit is synchronous to the clock.
 */
module verify_latch (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Control
	input wire logic armed,
	input wire logic clear,
	input wire logic diag,
	// Result
	output logic verified
);

	logic diagLast;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			diagLast <= 1'b0;
		end else begin
			diagLast <= diag;
		end
	end

	// A change of state seen while armed wins over a clear in the same cycle.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			verified <= 1'b0;
		end else if (armed && (diag != diagLast)) begin
			verified <= 1'b1;
		end else if (clear) begin
			verified <= 1'b0;
		end
	end

endmodule

// File: logic/startup_selftest_fault_report.sv
/*
 * Startup self-test sequencer, enable combining and hardwired fault reporting.
 * Assumes detector outputs and pin feedback are synchronous to ref_clk and rst is the
 * internal power-on reset. Status leaves as plain ports for the serial interface.
 */


module startup_selftest_fault_report (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Enable inputs
	input wire logic logic_level_enable_in,
	input wire logic battery_level_enable_in,
	// Detector outputs from the analog monitors
	input wire selftest_pkg::detect_t detect,
	input wire logic monitorRefFail,
	input wire logic otherFault,
	// Power-on-enable demand and sensed pin level
	input wire logic powerOnEnableDemand,
	input wire logic powerOnEnableSense,
	// Host controls from the serial interface
	input wire logic sensorRail1Enable,
	input wire logic sensorRail2Enable,
	input wire logic verifyClear,
	// Stimulus and enables to the analog side
	output logic regulatorsEnable,
	output logic [4:0] uvStimulus,
	output logic [4:0] ovStimulus,
	output logic overtempStimulus,
	output logic [1:0] sensorRailEnable,
	// Fault pins and status
	output logic supply_good_reset_n,
	output logic fault_flag_n,
	output selftest_pkg::status_t status,
	output logic [7:0] verifyResult0
);

	// ****************************************************************
	// Declarations
	// ****************************************************************
	selftest_pkg::seq_state_t state;
	selftest_pkg::seq_state_t next_state;
	logic [11:0] stepCount;
	logic stepEnd;
	logic [4:0] uvVerify;
	logic [4:0] ovVerify;
	logic overtempVerify;
	logic enableOutputMatchOk;
	logic testDone;
	logic uvFail;
	logic ovFail;
	logic overtempFail;
	logic testing;
	logic realUv;
	logic realOv;
	logic next_faultFlagN;
	logic next_supplyGoodN;

	// ****************************************************************
	// Enable combining
	// ****************************************************************
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			regulatorsEnable <= 1'b0;
		end else begin
			regulatorsEnable <= logic_level_enable_in | battery_level_enable_in;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			sensorRailEnable <= 2'h0;
		end else begin
			sensorRailEnable <= {sensorRail2Enable, sensorRail1Enable};
		end
	end

	// ****************************************************************
	// Sequencer
	// ****************************************************************
	// Each phase lasts one step; the counter restarts on every change of state.
	assign stepEnd = (stepCount == selftest_pkg::STEP_LAST);

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			stepCount <= selftest_pkg::CNT_ZERO;
		end else if ((state != next_state) || stepEnd) begin
			stepCount <= selftest_pkg::CNT_ZERO;
		end else if (testing) begin
			stepCount <= stepCount + 12'h001;
		end
	end

	always_comb begin
		next_state = state;
		case (state)
			selftest_pkg::ST_IDLE: begin
				if (regulatorsEnable) begin
					next_state = selftest_pkg::ST_UV_TEST;
				end
			end
			selftest_pkg::ST_UV_TEST: begin
				if (stepEnd) begin
					next_state = selftest_pkg::ST_OV_TEST;
				end
			end
			selftest_pkg::ST_OV_TEST: begin
				if (stepEnd) begin
					next_state = selftest_pkg::ST_OT_TEST;
				end
			end
			selftest_pkg::ST_OT_TEST: begin
				if (stepEnd) begin
					next_state = selftest_pkg::ST_SETTLE;
				end
			end
			selftest_pkg::ST_SETTLE: begin
				if (stepEnd) begin
					next_state = selftest_pkg::ST_DONE;
				end
			end
			selftest_pkg::ST_DONE: begin
				next_state = selftest_pkg::ST_DONE;
			end
			default: begin
				next_state = selftest_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state <= selftest_pkg::ST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	assign testing = (state == selftest_pkg::ST_UV_TEST) || (state == selftest_pkg::ST_OV_TEST)
		|| (state == selftest_pkg::ST_OT_TEST) || (state == selftest_pkg::ST_SETTLE);

	// ****************************************************************
	// Stimulus
	// ****************************************************************
	// Stimulus is taken from the next state, so it rises as its phase begins.
	// Only one kind of stimulus is ever applied at a time.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			uvStimulus <= selftest_pkg::RAILS_NONE;
			ovStimulus <= selftest_pkg::RAILS_NONE;
			overtempStimulus <= 1'b0;
		end else begin
			uvStimulus <= (next_state == selftest_pkg::ST_UV_TEST) ?
				selftest_pkg::RAILS_ALL : selftest_pkg::RAILS_NONE;
			ovStimulus <= (next_state == selftest_pkg::ST_OV_TEST) ?
				selftest_pkg::RAILS_ALL : selftest_pkg::RAILS_NONE;
			overtempStimulus <= (next_state == selftest_pkg::ST_OT_TEST);
		end
	end

	// ****************************************************************
	// Verify bits
	// ****************************************************************
	// Each verify bit is armed only during the phase of its own detector.
	genvar gi;
	generate
		for (gi = 0; gi < selftest_pkg::RAIL_COUNT; gi++) begin : gRail
			verify_latch uUv (
				.ref_clk(ref_clk),
				.rst(rst),
				.armed(state == selftest_pkg::ST_UV_TEST),
				.clear(verifyClear),
				.diag(detect.uvDiag[gi]),
				.verified(uvVerify[gi])
			);
			verify_latch uOv (
				.ref_clk(ref_clk),
				.rst(rst),
				.armed(state == selftest_pkg::ST_OV_TEST),
				.clear(verifyClear),
				.diag(detect.ovDiag[gi]),
				.verified(ovVerify[gi])
			);
		end
	endgenerate

	verify_latch uOt (
		.ref_clk(ref_clk),
		.rst(rst),
		.armed(state == selftest_pkg::ST_OT_TEST),
		.clear(verifyClear),
		.diag(detect.overtempDiag),
		.verified(overtempVerify)
	);

	// ****************************************************************
	// Results
	// ****************************************************************
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			testDone <= 1'b0;
			uvFail <= 1'b0;
			ovFail <= 1'b0;
			overtempFail <= 1'b0;
		end else if ((state == selftest_pkg::ST_SETTLE) && stepEnd) begin
			// The verdict is taken once, after the last response has settled.
			testDone <= 1'b1;
			uvFail <= (uvVerify != selftest_pkg::RAILS_ALL);
			ovFail <= (ovVerify != selftest_pkg::RAILS_ALL);
			overtempFail <= ~overtempVerify;
		end
	end

	// The match bit starts high so that reset alone raises no fault.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			enableOutputMatchOk <= 1'b1;
		end else begin
			enableOutputMatchOk <= (powerOnEnableSense == powerOnEnableDemand);
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			status <= '0;
			verifyResult0 <= selftest_pkg::VR0_RESET;
		end else begin
			status.uvVerify <= uvVerify;
			status.ovVerify <= ovVerify;
			status.overtempVerify <= overtempVerify;
			status.uvFail <= uvFail;
			status.ovFail <= ovFail;
			status.overtempFail <= overtempFail;
			status.testDone <= testDone;
			status.enableOutputMatchOk <= enableOutputMatchOk;
			verifyResult0 <= selftest_pkg::VR0_RESET;
			verifyResult0[selftest_pkg::VR0_OVERTEMP_BIT] <= overtempVerify;
		end
	end

	// ****************************************************************
	// Fault pins
	// ****************************************************************
	assign realUv = testDone && (detect.uvDiag != selftest_pkg::RAILS_NONE);
	assign realOv = testDone && (detect.ovDiag != selftest_pkg::RAILS_NONE);

	// Supply good stays low until the self-test has finished, whether it passed or failed.
	always_comb begin
		next_supplyGoodN = 1'b1;
		if (testDone && (detect.uvDiag[selftest_pkg::RAIL_UC] || detect.ovDiag[selftest_pkg::RAIL_UC])) begin
			next_supplyGoodN = 1'b0;
		end
		if (!testDone) begin
			next_supplyGoodN = 1'b0;
		end
	end

	// Undervoltage and overvoltage detector trips count as faults only once the self-test has finished.
	always_comb begin
		next_faultFlagN = 1'b1;
		if (realUv || realOv || otherFault || monitorRefFail) begin
			next_faultFlagN = 1'b0;
		end
		if (state == selftest_pkg::ST_OT_TEST) begin
			next_faultFlagN = 1'b0;
		end
		if (!enableOutputMatchOk) begin
			next_faultFlagN = 1'b0;
		end
		if (testDone && (uvFail || ovFail || overtempFail)) begin
			next_faultFlagN = 1'b0;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			supply_good_reset_n <= 1'b0;
			fault_flag_n <= 1'b1;
		end else begin
			supply_good_reset_n <= next_supplyGoodN;
			fault_flag_n <= next_faultFlagN;
		end
	end

endmodule

// File: sim/selftest_sva.sv
/*
 * Port assertions for the startup self-test block.
 * Assumes it is bound to the block by the bench top file.
 */
module selftest_sva (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Inputs
	input wire logic logic_level_enable_in,
	input wire logic battery_level_enable_in,
	input wire selftest_pkg::detect_t detect,
	input wire logic monitorRefFail,
	input wire logic otherFault,
	input wire logic powerOnEnableDemand,
	input wire logic powerOnEnableSense,
	input wire logic sensorRail1Enable,
	input wire logic sensorRail2Enable,
	input wire logic verifyClear,
	// Outputs
	input wire logic regulatorsEnable,
	input wire logic [4:0] uvStimulus,
	input wire logic [4:0] ovStimulus,
	input wire logic overtempStimulus,
	input wire logic [1:0] sensorRailEnable,
	input wire logic supply_good_reset_n,
	input wire logic fault_flag_n,
	input wire selftest_pkg::status_t status
);
	// ****************************************
	// Properties
	// ****************************************
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	wire [10:0] vbits = {status.uvVerify, status.ovVerify, status.overtempVerify};
	property p_en;
		!$past(rst) |-> regulatorsEnable == $past(logic_level_enable_in | battery_level_enable_in);
	endproperty
	a_en: assert property (p_en) else $error("enable mismatch");
	property p_rails;
		!$past(rst) |-> sensorRailEnable == $past({sensorRail2Enable, sensorRail1Enable});
	endproperty
	a_rails: assert property (p_rails) else $error("rail enable mismatch");
	property p_match;
		powerOnEnableDemand != powerOnEnableSense |->
			##2 !status.enableOutputMatchOk && !fault_flag_n;
	endproperty
	a_match: assert property (p_match) else $error("pin mismatch missed");
	property p_other;
		otherFault |-> ##1 !fault_flag_n;
	endproperty
	a_other: assert property (p_other) else $error("fault flag missed");
	property p_ref;
		monitorRefFail && status.testDone |-> ##1 !fault_flag_n;
	endproperty
	a_ref: assert property (p_ref) else $error("reference fault missed");
	property p_ot;
		$rose(overtempStimulus) |-> ##[1:2] !fault_flag_n;
	endproperty
	a_ot: assert property (p_ot) else $error("overtemp test flag missed");
	property p_sticky;
		!$past(verifyClear) && !$past(verifyClear, 2) |-> (vbits & $past(vbits)) == $past(vbits);
	endproperty
	a_sticky: assert property (p_sticky) else $error("verify bit lost");
	property p_done;
		status.testDone |-> uvStimulus == 5'h00 && ovStimulus == 5'h00 && !overtempStimulus;
	endproperty
	a_done: assert property (p_done) else $error("stimulus after test");
	property p_all;
		|uvStimulus |-> uvStimulus == selftest_pkg::RAILS_ALL && ovStimulus == 5'h00;
	endproperty
	a_all: assert property (p_all) else $error("undervoltage stimulus partial");
	property p_supply_good_reset_n;
		(detect.uvDiag[1] || detect.ovDiag[1]) && status.testDone |-> ##1 !supply_good_reset_n;
	endproperty
	a_supply_good_reset_n: assert property (p_supply_good_reset_n) else $error("supply good missed");
endmodule

// File: sim/monitor_model.sv
/*
 * Model of the analog comparators facing the block.
 * Assumes the bench sets which detectors are dead and which rails are faulty.
 */
module monitor_model (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Stimulus from the block
	input wire logic [4:0] uvStimulus,
	input wire logic [4:0] ovStimulus,
	input wire logic overtempStimulus,
	// Bench controls
	input wire logic [10:0] dead,
	input wire logic [10:0] fault,
	// Comparator outputs
	output selftest_pkg::detect_t detect
);
	// ****************************************
	// Comparators
	// ****************************************
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			detect <= '0;
		end else begin
			detect <= ({uvStimulus, ovStimulus, overtempStimulus} & ~dead) | fault;
		end
	end
endmodule

// File: sim/tb_top.sv
/*
 * Self-checking bench for the startup self-test block.
 * Assumes the package, design, model and checker are compiled first.
 */
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	// ****************************************
	// Signals
	// ****************************************
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic logic_level_enable_in = 1'b0;
	logic battery_level_enable_in = 1'b0;
	logic monitorRefFail = 1'b0;
	logic otherFault = 1'b0;
	logic powerOnEnableDemand = 1'b0;
	logic powerOnEnableSense = 1'b0;
	logic sensorRail1Enable = 1'b0;
	logic sensorRail2Enable = 1'b0;
	logic verifyClear = 1'b0;
	logic [10:0] dead = 11'h000;
	logic [10:0] fault = 11'h000;
	logic [7:0] lfsr = 8'h35;
	selftest_pkg::detect_t detect;
	selftest_pkg::status_t status;
	logic regulatorsEnable, overtempStimulus, supply_good_reset_n, fault_flag_n;
	logic [4:0] uvStimulus, ovStimulus;
	logic [1:0] sensorRailEnable;
	logic [7:0] verifyResult0;
	int n_mismatch = 0;
	int comparisons = 0;
	startup_selftest_fault_report startup_selftest_fault_report_i (.ref_clk, .rst,
		.logic_level_enable_in, .battery_level_enable_in, .detect, .monitorRefFail,
		.otherFault, .powerOnEnableDemand, .powerOnEnableSense, .sensorRail1Enable,
		.sensorRail2Enable, .verifyClear, .regulatorsEnable, .uvStimulus, .ovStimulus,
		.overtempStimulus, .sensorRailEnable, .supply_good_reset_n, .fault_flag_n, .status,
		.verifyResult0);
	monitor_model monitor_model_i (.ref_clk, .rst, .uvStimulus, .ovStimulus,
		.overtempStimulus, .dead, .fault, .detect);
	// ****************************************
	// Tasks
	// ****************************************
	initial forever #5 ref_clk = ~ref_clk;
	function automatic logic [7:0] step(input logic [7:0] v);
		return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction
	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge ref_clk);
	endtask
	task automatic results;
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic startup(input logic viaBat, input logic [10:0] d);
		int i;
		logic otSeen;
		otSeen = 1'b0;
		rst = 1'b1;
		logic_level_enable_in = 1'b0;
		battery_level_enable_in = 1'b0;
		dead = d;
		cyc(12);
		rst = 1'b0;
		check("rails after reset", sensorRailEnable, 2'b00);
		check("pins after reset", {supply_good_reset_n, fault_flag_n}, 2'b01);
		cyc(1);
		if (viaBat) battery_level_enable_in = 1'b1;
		else logic_level_enable_in = 1'b1;
		cyc(2);
		check("regulators", regulatorsEnable, 1'b1);
		check("uv stimulus", uvStimulus, 5'h1F);
		for (i = 0; i < 6000 && status.testDone !== 1'b1; i++) begin
			cyc(1);
			if (overtempStimulus === 1'b1 && fault_flag_n === 1'b0) otSeen = 1'b1;
		end
		if (i == 6000) begin
			n_mismatch++;
			results();
		end
		check("ot test flag", otSeen, 1'b1);
		cyc(3);
		check("uv verify", status.uvVerify, d[10:6] ^ 5'h1F);
		check("ov verify", status.ovVerify, d[5:1] ^ 5'h1F);
		check("ot verify", verifyResult0, {7'h00, !d[0]});
		check("fails", {status.uvFail, status.ovFail, status.overtempFail},
			{|d[10:6], |d[5:1], d[0]});
		check("flag after test", fault_flag_n, d == 11'h000);
		check("supply good", supply_good_reset_n, 1'b1);
	endtask
	// ****************************************
	// Scenarios
	// ****************************************
	initial begin
		startup(1'b0, 11'h000);
		otherFault = 1'b1;
		cyc(3);
		check("other fault", fault_flag_n, 1'b0);
		otherFault = 1'b0;
		monitorRefFail = 1'b1;
		cyc(3);
		check("reference fault", fault_flag_n, 1'b0);
		monitorRefFail = 1'b0;
		powerOnEnableSense = 1'b1;
		cyc(4);
		check("match bit", status.enableOutputMatchOk, 1'b0);
		check("match flag", fault_flag_n, 1'b0);
		powerOnEnableSense = 1'b0;
		verifyClear = 1'b1;
		cyc(1);
		verifyClear = 1'b0;
		fault = 11'h082;
		cyc(3);
		check("supply fault", supply_good_reset_n, 1'b0);
		check("cleared verify", {status.uvVerify, status.ovVerify}, 10'h000);
		check("cleared result", verifyResult0, 8'h00);
		fault = 11'h000;
		repeat (8) begin
			lfsr = step(lfsr);
			sensorRail1Enable = lfsr[0];
			sensorRail2Enable = lfsr[1];
			powerOnEnableDemand = lfsr[2];
			powerOnEnableSense = lfsr[2];
			cyc(2);
			check("rail enable", sensorRailEnable, {lfsr[1], lfsr[0]});
		end
		lfsr = step(lfsr);
		startup(1'b1, {lfsr[4:0], lfsr[7:2]} | 11'h040);
		verifyClear = 1'b1;
		cyc(3);
		check("fails stand", status.uvFail, 1'b1);
		results();
	end
endmodule
bind startup_selftest_fault_report selftest_sva selftest_sva_i (.ref_clk, .rst,
	.logic_level_enable_in, .battery_level_enable_in, .detect, .monitorRefFail, .otherFault,
	.powerOnEnableDemand, .powerOnEnableSense, .sensorRail1Enable, .sensorRail2Enable,
	.verifyClear, .regulatorsEnable, .uvStimulus, .ovStimulus, .overtempStimulus,
	.sensorRailEnable, .supply_good_reset_n, .fault_flag_n, .status);
